// ==== logic/its_supervisor.sv ====
/*
 * Instrument transformer supervisor: current and voltage transformer
 * supervision with delayed alarms, events, records and an APB slave.
 * Assumes phasors from the measurement chain on CLK, strobed by
 * MEAS_VALID, and a running date/time word on TIMESTAMP.
 */
// Functional notes
// - CT fault: a phase under the low, another over the high threshold.
// - The upper CT threshold spans 0 to 10 x In and resets to 2 x In.
// - The lower CT threshold has the same span and resets to 0.2 x In.
// - Alarm once a fault lasts its delay: 0.02 to 600 s, reset 0.10 s.
// - CT alarm start and end events, each with an enable that resets on.
// - A CT alarm records the time and the phase current extremes.
// - The largest and smallest phase currents are always readable.
// - Both CT thresholds are readable in primary units.
// - Negative sequence voltage and current derive from the phasors.
// - VT fault: negative sequence voltage over, current under its limit.
// - The voltage limit spans 0 to 200 % Un and resets to 34.6 %.
// - The current limit spans 0 to 200 % In and resets to 100 %.
// - VT alarm start and end events, each with an enable that resets on.
// - A VT alarm records the time and both negative sequence values.
// - Negative sequence voltage and current are always readable.
`timescale 1ns/10ps
module its_supervisor #(
  parameter int MS_CYCLES = its_pkg::ITS_MS_CYCLES
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Measurement chain
  input wire logic MEAS_VALID,
  input wire its_pkg::its_tri_t I_PH,
  input wire its_pkg::its_tri_t U_PH,
  input wire logic [63:0] TIMESTAMP,
  // Supervision results
  output logic CT_ALARM,
  output logic VT_ALARM,
  output logic CUR_XFORMER_ALARM_START_EVENT_EN_EVT,
  output logic CUR_XFORMER_ALARM_END_EVENT_EN_EVT,
  output logic VOLT_XFORMER_ALARM_START_EVENT_EN_EVT,
  output logic VOLT_XFORMER_ALARM_END_EVENT_EN_EVT,
  output logic IRQ
);
  import its_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [3:0] evt_en, sts, mask, evt;
    logic [15:0] ct_up, ct_lo, u2_lim, i2_lim, ct_pri;
    logic [19:0] ct_dly, vt_dly;
    logic [2:0][15:0] imag;
    logic [15:0] u2, i2;
    its_tmr_t ct_t, vt_t;
    logic [15:0] ct_rmax, ct_rmin, vt_ru2, vt_ri2;
    logic [63:0] ct_rts, vt_rts;
    logic [13:0] div;
    logic tick, irq, pready, pslverr;
    logic [31:0] prdata;
  } its_state_t;

  localparam its_state_t RST_ST = '{
    evt_en: ITS_RST_EVT_EN, ct_up: ITS_RST_CT_UP, ct_lo: ITS_RST_CT_LO,
    u2_lim: ITS_RST_U2_LIM, i2_lim: ITS_RST_I2_LIM,
    ct_pri: ITS_RST_CT_PRI, ct_dly: ITS_RST_DLY, vt_dly: ITS_RST_DLY,
    default: '0};

  its_state_t st;
  its_state_t next_st;
  logic [15:0] cmax, cmin;
  logic ct_cond, vt_cond, hit, wr;
  logic [31:0] rd;
  logic [3:0] clr;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Max plus half min: within about 12 % of the true magnitude,
  // traded for no square root in the measurement path.
  function automatic logic [15:0] its_mag(input logic signed [31:0] re,
                                          input logic signed [31:0] im);
    logic [31:0] ar, ai, hi, lo, m;
    ar = (re < 0) ? -re : re;
    ai = (im < 0) ? -im : im;
    hi = (ar > ai) ? ar : ai;
    lo = (ar > ai) ? ai : ar;
    m = hi + (lo >> 1);
    return (m > 32'h0000FFFF) ? 16'hFFFF : m[15:0];
  endfunction

  // (A + a^2 B + a C) / 3, a = 1 at 120 degrees; sqrt3 and 1/6
  // are fixed point in 1024ths
  function automatic logic [15:0] its_negseq(input its_tri_t p);
    logic signed [31:0] re, im;
    re = 2 * p[0].re - p[1].re - p[2].re
         + ((32'sd1774 * (p[1].im - p[2].im)) >>> 10);
    im = 2 * p[0].im - p[1].im - p[2].im
         + ((32'sd1774 * (p[2].re - p[1].re)) >>> 10);
    re = (re * 32'sd171) >>> 10;
    im = (im * 32'sd171) >>> 10;
    return its_mag(re, im);
  endfunction

  function automatic its_tmr_t its_step(input logic cond,
                                        input logic tick,
                                        input its_tmr_t t,
                                        input logic [19:0] dly);
    its_tmr_t r;
    r = t;
    if (!cond) begin
      r.cnt = '0;
      r.alarm = 1'b0;
    end else if (t.cnt >= dly) begin
      r.alarm = 1'b1;
    end else if (tick) begin
      r.cnt = t.cnt + 20'h00001;
    end
    return r;
  endfunction

  // Out of range writes saturate rather than being refused
  function automatic logic [19:0] its_clamp(input logic [31:0] v,
                                            input logic [19:0] lo,
                                            input logic [19:0] hi);
    if (v < {12'h000, lo}) return lo;
    if (v > {12'h000, hi}) return hi;
    return v[19:0];
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_st = st;
    cmax = st.imag[0];
    cmin = st.imag[0];
    for (int k = 1; k < 3; k++) begin
      if (st.imag[k] > cmax) cmax = st.imag[k];
      if (st.imag[k] < cmin) cmin = st.imag[k];
    end
    ct_cond = 1'b0;
    for (int i = 0; i < 3; i++) begin
      for (int j = 0; j < 3; j++) begin
        if (i != j && st.imag[i] < st.ct_lo && st.imag[j] > st.ct_up)
          ct_cond = 1'b1;
      end
    end
    vt_cond = (st.u2 > st.u2_lim) && (st.i2 < st.i2_lim);

    // Millisecond tick for the delay timers
    next_st.tick = (st.div == 14'(MS_CYCLES - 1));
    next_st.div = next_st.tick ? '0 : st.div + 14'h0001;

    if (MEAS_VALID) begin
      for (int k = 0; k < 3; k++)
        next_st.imag[k] = its_mag(32'(I_PH[k].re), 32'(I_PH[k].im));
      next_st.u2 = its_negseq(U_PH);
      next_st.i2 = its_negseq(I_PH);
    end

    next_st.ct_t = its_step(ct_cond, st.tick, st.ct_t, st.ct_dly);
    next_st.vt_t = its_step(vt_cond, st.tick, st.vt_t, st.vt_dly);

    next_st.evt[ITS_EV_CUR_XFORMER_ALARM_START_EVENT_EN] = next_st.ct_t.alarm & ~st.ct_t.alarm
                                & st.evt_en[ITS_EV_CUR_XFORMER_ALARM_START_EVENT_EN];
    next_st.evt[ITS_EV_CUR_XFORMER_ALARM_END_EVENT_EN] = ~next_st.ct_t.alarm & st.ct_t.alarm
                                 & st.evt_en[ITS_EV_CUR_XFORMER_ALARM_END_EVENT_EN];
    next_st.evt[ITS_EV_VOLT_XFORMER_ALARM_START_EVENT_EN] = next_st.vt_t.alarm & ~st.vt_t.alarm
                                & st.evt_en[ITS_EV_VOLT_XFORMER_ALARM_START_EVENT_EN];
    next_st.evt[ITS_EV_VOLT_XFORMER_ALARM_END_EVENT_EN] = ~next_st.vt_t.alarm & st.vt_t.alarm
                                 & st.evt_en[ITS_EV_VOLT_XFORMER_ALARM_END_EVENT_EN];

    if (next_st.ct_t.alarm && !st.ct_t.alarm) begin
      next_st.ct_rmax = cmax;
      next_st.ct_rmin = cmin;
      next_st.ct_rts = TIMESTAMP;
    end
    if (next_st.vt_t.alarm && !st.vt_t.alarm) begin
      next_st.vt_ru2 = st.u2;
      next_st.vt_ri2 = st.i2;
      next_st.vt_rts = TIMESTAMP;
    end

    // Register read
    hit = 1'b1;
    rd = '0;
    case (PADDR)
      ITS_A_CTRL: rd = {28'h0000000, st.evt_en};
      ITS_A_CT_UP: rd = {16'h0000, st.ct_up};
      ITS_A_CT_LO: rd = {16'h0000, st.ct_lo};
      ITS_A_CT_DLY: rd = {12'h000, st.ct_dly};
      ITS_A_U2_LIM: rd = {16'h0000, st.u2_lim};
      ITS_A_I2_LIM: rd = {16'h0000, st.i2_lim};
      ITS_A_VT_DLY: rd = {12'h000, st.vt_dly};
      ITS_A_CT_PRI: rd = {16'h0000, st.ct_pri};
      ITS_A_STATUS: begin
        rd = {28'h0000000, st.sts};
        rd[ITS_ST_CT_ALARM] = st.ct_t.alarm;
        rd[ITS_ST_VT_ALARM] = st.vt_t.alarm;
      end
      ITS_A_MASK: rd = {28'h0000000, st.mask};
      ITS_A_LIVE_CT: rd = {cmax, cmin};
      ITS_A_LIVE_VT: rd = {st.u2, st.i2};
      // Widen first so the product keeps all 32 bits
      ITS_A_UP_PRI: rd = 32'(st.ct_up) * 32'(st.ct_pri);
      ITS_A_LO_PRI: rd = 32'(st.ct_lo) * 32'(st.ct_pri);
      ITS_A_CT_RVAL: rd = {st.ct_rmax, st.ct_rmin};
      ITS_A_CT_RTLO: rd = st.ct_rts[31:0];
      ITS_A_CT_RTHI: rd = st.ct_rts[63:32];
      ITS_A_VT_RVAL: rd = {st.vt_ru2, st.vt_ri2};
      ITS_A_VT_RTLO: rd = st.vt_rts[31:0];
      ITS_A_VT_RTHI: rd = st.vt_rts[63:32];
      default: hit = 1'b0;
    endcase

    // Answer is prepared in the setup cycle so the access needs no wait
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    if (PSEL && !PENABLE) begin
      next_st.pready = 1'b1;
      next_st.pslverr = ~hit;
      next_st.prdata = hit ? rd : '0;
    end

    // Register write
    wr = PSEL & PENABLE & PWRITE & st.pready & ~st.pslverr;
    clr = '0;
    if (wr) begin
      case (PADDR)
        ITS_A_CTRL: next_st.evt_en = PWDATA[3:0];
        ITS_A_CT_UP:
          next_st.ct_up = 16'(its_clamp(PWDATA, '0,
                                        {4'h0, ITS_CT_MAX}));
        ITS_A_CT_LO:
          next_st.ct_lo = 16'(its_clamp(PWDATA, '0,
                                        {4'h0, ITS_CT_MAX}));
        ITS_A_CT_DLY:
          next_st.ct_dly = its_clamp(PWDATA, ITS_DLY_MIN,
                                     ITS_DLY_MAX);
        ITS_A_U2_LIM:
          next_st.u2_lim = 16'(its_clamp(PWDATA, '0,
                                         {4'h0, ITS_NS_MAX}));
        ITS_A_I2_LIM:
          next_st.i2_lim = 16'(its_clamp(PWDATA, '0,
                                         {4'h0, ITS_NS_MAX}));
        ITS_A_VT_DLY:
          next_st.vt_dly = its_clamp(PWDATA, ITS_DLY_MIN,
                                     ITS_DLY_MAX);
        ITS_A_CT_PRI: next_st.ct_pri = PWDATA[15:0];
        ITS_A_STATUS: clr = PWDATA[3:0];
        ITS_A_MASK: next_st.mask = PWDATA[3:0];
        default: ;
      endcase
    end

    // A new event wins over a clear in the same cycle
    next_st.sts = (st.sts & ~clr) | next_st.evt;
    next_st.irq = |(next_st.sts & next_st.mask);
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) st <= RST_ST;
    else st <= next_st;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // The VT alarm doubles as the block for voltage based protection
  assign VT_ALARM = st.vt_t.alarm;
  assign CT_ALARM = st.ct_t.alarm;
  assign CUR_XFORMER_ALARM_START_EVENT_EN_EVT = st.evt[ITS_EV_CUR_XFORMER_ALARM_START_EVENT_EN];
  assign CUR_XFORMER_ALARM_END_EVENT_EN_EVT = st.evt[ITS_EV_CUR_XFORMER_ALARM_END_EVENT_EN];
  assign VOLT_XFORMER_ALARM_START_EVENT_EN_EVT = st.evt[ITS_EV_VOLT_XFORMER_ALARM_START_EVENT_EN];
  assign VOLT_XFORMER_ALARM_END_EVENT_EN_EVT = st.evt[ITS_EV_VOLT_XFORMER_ALARM_END_EVENT_EN];
  assign IRQ = st.irq;
  assign PRDATA = st.prdata;
  assign PREADY = st.pready;
  assign PSLVERR = st.pslverr;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  AST_CT_COND:
    assert property (ct_cond |-> cmin < st.ct_lo && cmax > st.ct_up)
    else $error("CT fault without a low and a high phase");
  AST_CT_UP_RANGE:
    assert property (st.ct_up <= ITS_CT_MAX)
    else $error("Upper CT threshold out of range");
  AST_CT_LO_RANGE:
    assert property (st.ct_lo <= ITS_CT_MAX)
    else $error("Lower CT threshold out of range");
  AST_CT_DELAY:
    assert property ($rose(st.ct_t.alarm) |->
                     $past(st.ct_t.cnt) >= $past(st.ct_dly) &&
                     $past(st.ct_dly) >= ITS_DLY_MIN)
    else $error("CT alarm before its delay");
  AST_CT_EVT:
    assert property ($fell(st.ct_t.alarm) |->
                     st.evt[ITS_EV_CUR_XFORMER_ALARM_END_EVENT_EN] == $past(st.evt_en[1]) ##1
                     !st.evt[ITS_EV_CUR_XFORMER_ALARM_END_EVENT_EN])
    else $error("CT end event wrong");
  AST_CT_REC:
    assert property ($rose(st.ct_t.alarm) |->
                     st.ct_rts == $past(TIMESTAMP) &&
                     st.ct_rmax == $past(cmax) && st.ct_rmin == $past(cmin))
    else $error("CT record not taken");
  AST_LIVE_CT:
    assert property (cmax >= st.imag[1] && cmax >= st.imag[2] &&
                     cmin <= st.imag[1] && cmin <= st.imag[2])
    else $error("Live CT extremes wrong");
  AST_VT_CAUSE:
    assert property (st.vt_t.alarm |->
                     $past(st.u2 > st.u2_lim && st.i2 < st.i2_lim))
    else $error("VT alarm without its condition");
  AST_NS_RANGE:
    assert property (st.u2_lim <= ITS_NS_MAX && st.i2_lim <= ITS_NS_MAX)
    else $error("Negative sequence limit out of range");
  AST_VT_EVT:
    assert property ($rose(st.vt_t.alarm) |->
                     st.evt[ITS_EV_VOLT_XFORMER_ALARM_START_EVENT_EN] == $past(st.evt_en[2]))
    else $error("VT start event wrong");
  AST_VT_REC:
    assert property ($rose(st.vt_t.alarm) |->
                     st.vt_ru2 == $past(st.u2) && st.vt_ri2 == $past(st.i2))
    else $error("VT record not taken");
  AST_RESTART:
    assert property (!ct_cond |=> st.ct_t.cnt == 0 && !st.ct_t.alarm)
    else $error("CT timer not restarted");
  AST_CT_CAUSE:
    assert property (st.ct_t.alarm |-> $past(ct_cond))
    else $error("CT alarm without its condition");
  AST_DLY_RANGE:
    assert property (st.ct_dly >= ITS_DLY_MIN && st.ct_dly <= ITS_DLY_MAX &&
                     st.vt_dly >= ITS_DLY_MIN && st.vt_dly <= ITS_DLY_MAX)
    else $error("Operation delay out of range");
  AST_VT_DELAY:
    assert property ($rose(st.vt_t.alarm) |->
                     $past(st.vt_t.cnt) >= $past(st.vt_dly))
    else $error("VT alarm before its delay");
  AST_CUR_XFORMER_ALARM_START_EVENT_EN_EVT:
    assert property ($rose(st.ct_t.alarm) |->
                     st.evt[ITS_EV_CUR_XFORMER_ALARM_START_EVENT_EN] == $past(st.evt_en[ITS_EV_CUR_XFORMER_ALARM_START_EVENT_EN]))
    else $error("CT start event wrong");
  AST_STS_SET:
    assert property (st.evt[ITS_EV_CUR_XFORMER_ALARM_START_EVENT_EN] |-> st.sts[ITS_EV_CUR_XFORMER_ALARM_START_EVENT_EN])
    else $error("CT start event not kept in status");
  AST_VOLT_XFORMER_ALARM_END_EVENT_EN_EVT:
    assert property ($fell(st.vt_t.alarm) |->
                     st.evt[ITS_EV_VOLT_XFORMER_ALARM_END_EVENT_EN] == $past(st.evt_en[ITS_EV_VOLT_XFORMER_ALARM_END_EVENT_EN]))
    else $error("VT end event wrong");
  AST_LIVE_VT_HOLD:
    assert property (!MEAS_VALID |=> $stable(st.u2) && $stable(st.i2))
    else $error("Live negative sequence values moved without a strobe");
  AST_CT_FALL:
    assert property ($fell(st.ct_t.alarm) |-> !$past(ct_cond))
    else $error("CT alarm cleared while its fault stands");
  AST_VT_RESTART:
    assert property (!vt_cond |=> st.vt_t.cnt == 0 && !st.vt_t.alarm)
    else $error("VT timer not restarted");
  // A ready that stood on would let one access write twice
  AST_PREADY_ONE:
    assert property (st.pready |=> !st.pready)
    else $error("Bus ready stood longer than one cycle");

endmodule

// ==== logic/its_pkg.sv ====
/*
 * Package of the instrument transformer supervisor: register map,
 * reset values, setting ranges, timing counts and carrier types.
 * Assumes a single 10 MHz processing clock.
 */
package its_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int ITS_CLK_NS = 100;
  localparam int ITS_TICK_US = 1000;
  localparam int ITS_MS_CYCLES = ITS_TICK_US * 1000 / ITS_CLK_NS;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] ITS_A_CTRL = 8'h00;
  localparam logic [7:0] ITS_A_CT_UP = 8'h04;
  localparam logic [7:0] ITS_A_CT_LO = 8'h08;
  localparam logic [7:0] ITS_A_CT_DLY = 8'h0C;
  localparam logic [7:0] ITS_A_U2_LIM = 8'h10;
  localparam logic [7:0] ITS_A_I2_LIM = 8'h14;
  localparam logic [7:0] ITS_A_VT_DLY = 8'h18;
  localparam logic [7:0] ITS_A_CT_PRI = 8'h1C;
  localparam logic [7:0] ITS_A_STATUS = 8'h20;
  localparam logic [7:0] ITS_A_MASK = 8'h24;
  localparam logic [7:0] ITS_A_LIVE_CT = 8'h28;
  localparam logic [7:0] ITS_A_LIVE_VT = 8'h2C;
  localparam logic [7:0] ITS_A_UP_PRI = 8'h30;
  localparam logic [7:0] ITS_A_LO_PRI = 8'h34;
  localparam logic [7:0] ITS_A_CT_RVAL = 8'h38;
  localparam logic [7:0] ITS_A_CT_RTLO = 8'h3C;
  localparam logic [7:0] ITS_A_CT_RTHI = 8'h40;
  localparam logic [7:0] ITS_A_VT_RVAL = 8'h44;
  localparam logic [7:0] ITS_A_VT_RTLO = 8'h48;
  localparam logic [7:0] ITS_A_VT_RTHI = 8'h4C;

  // ****************************************************************
  // Event bits (control enables, status, mask share this layout)
  // ****************************************************************
  localparam int ITS_EV_CUR_XFORMER_ALARM_START_EVENT_EN = 0;
  localparam int ITS_EV_CUR_XFORMER_ALARM_END_EVENT_EN = 1;
  localparam int ITS_EV_VOLT_XFORMER_ALARM_START_EVENT_EN = 2;
  localparam int ITS_EV_VOLT_XFORMER_ALARM_END_EVENT_EN = 3;
  localparam int ITS_ST_CT_ALARM = 8;
  localparam int ITS_ST_VT_ALARM = 9;

  // ****************************************************************
  // Reset values and ranges (current 0.001 In, voltage 0.1 % Un)
  // ****************************************************************
  localparam logic [3:0] ITS_RST_EVT_EN = 4'hF;
  localparam logic [15:0] ITS_CT_MAX = 16'h2710;
  localparam logic [15:0] ITS_RST_CT_UP = 16'h07D0;
  localparam logic [15:0] ITS_RST_CT_LO = 16'h00C8;
  localparam logic [15:0] ITS_NS_MAX = 16'h07D0;
  localparam logic [15:0] ITS_RST_U2_LIM = 16'h015A;
  localparam logic [15:0] ITS_RST_I2_LIM = 16'h03E8;
  localparam logic [15:0] ITS_RST_CT_PRI = 16'h0064;
  localparam logic [19:0] ITS_DLY_MIN = 20'h00014;
  localparam logic [19:0] ITS_DLY_MAX = 20'h927C0;
  localparam logic [19:0] ITS_RST_DLY = 20'h00064;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic signed [15:0] re;
    logic signed [15:0] im;
  } its_phs_t;

  typedef its_phs_t [2:0] its_tri_t;

  typedef struct packed {
    logic [19:0] cnt;
    logic alarm;
  } its_tmr_t;

endpackage

// ==== testbench/its_meas_model.sv ====
/*
 * Measurement chain model for the supervisor bench: phasor patterns,
 * strobe and running date/time word. Assumes the bench selects the
 * pattern with MODE and the strobe rate with SLOW.
 */
`timescale 1ns/10ps
module its_meas_model (
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // Scenario control
  input wire logic [1:0] MODE,
  input wire logic SLOW,
  input wire logic VT_ALARM,
  // Measurement chain
  output logic MEAS_VALID,
  output its_pkg::its_tri_t I_PH,
  output its_pkg::its_tri_t U_PH,
  output logic [63:0] TIMESTAMP
);
  import its_pkg::*;
  // ****************************************************************
  // Pattern generator
  // ****************************************************************
  logic [1:0] gap;
  logic nv;
  logic volt_prot_blocked;
  its_phs_t a0, a1, a2, z;
  assign a0 = '{re: 16'sh0BB8, im: 16'sh0000};
  assign a1 = '{re: 16'sh0064, im: 16'sh0000};
  assign a2 = '{re: 16'sh03E8, im: 16'sh0000};
  assign z = '{re: 16'sh0000, im: 16'sh0000};
  assign nv = !SLOW || gap == 2'h0;
  // Voltage based protection held off while the VT alarm stands
  assign volt_prot_blocked = VT_ALARM;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      gap <= 2'h0;
      MEAS_VALID <= 1'b0;
      I_PH <= '0;
      U_PH <= '0;
      TIMESTAMP <= 64'h0000_0001_0000_0000;
    end else begin
      gap <= gap + 2'h1;
      MEAS_VALID <= nv;
      TIMESTAMP <= TIMESTAMP + 64'h1;
      if (!nv) begin
        // Stale data toggles so a late sample cannot pass by luck
        I_PH <= ~I_PH;
        U_PH <= ~U_PH;
      end else begin
        I_PH <= (MODE == 2'h1) ? {a2, a1, a0} : {z, z, z};
        U_PH <= (MODE == 2'h2) ? {z, z, a0} : {z, z, z};
      end
    end
  end
endmodule

// ==== testbench/its_supervisor_bench.sv ====
/*
 * Self-checking bench of the instrument transformer supervisor.
 * Assumes the design package and the measurement chain model.
 */
`timescale 1ns/10ps
module its_supervisor_bench;
  import its_pkg::*;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, meas_valid;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  its_tri_t i_ph, u_ph;
  logic [63:0] ts, ts_q, t_rise;
  logic ct_alarm, vt_alarm, cur_xformer_alarm_start_event_en, cur_xformer_alarm_end_event_en, volt_xformer_alarm_start_event_en, volt_xformer_alarm_end_event_en, irq, errv;
  logic [1:0] mode;
  logic slow;
  int failures, tests_run;
  its_supervisor #(.MS_CYCLES(10)) its_supervisor_i (.CLK(clk),
    .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .MEAS_VALID(meas_valid), .I_PH(i_ph),
    .U_PH(u_ph), .TIMESTAMP(ts), .CT_ALARM(ct_alarm),
    .VT_ALARM(vt_alarm), .CUR_XFORMER_ALARM_START_EVENT_EN_EVT(cur_xformer_alarm_start_event_en), .CUR_XFORMER_ALARM_END_EVENT_EN_EVT(cur_xformer_alarm_end_event_en),
    .VOLT_XFORMER_ALARM_START_EVENT_EN_EVT(volt_xformer_alarm_start_event_en), .VOLT_XFORMER_ALARM_END_EVENT_EN_EVT(volt_xformer_alarm_end_event_en), .IRQ(irq));
  its_meas_model its_meas_model_i (.CLK(clk), .NRST(nrst), .MODE(mode),
    .SLOW(slow), .VT_ALARM(vt_alarm), .MEAS_VALID(meas_valid),
    .I_PH(i_ph), .U_PH(u_ph), .TIMESTAMP(ts));
  always #50 clk = ~clk;
  always @(posedge clk) ts_q <= ts;
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic tally_and_finish();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, exp, input string m);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Magnitudes are approximate, so a window is accepted
  task automatic near(input logic [15:0] got, exp, tol, input string m);
    tests_run++;
    if ((^got === 1'bx) || got > exp + tol || got + tol < exp) begin
      failures++;
      $display("CHECK FAILED %0t %s got %0d", $time, m, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge, so a next call never reassigns psel in this step
    @(posedge clk);
    if (n == 20) begin
      failures++;
      $display("CHECK FAILED %0t bus answer missing", $time);
      tally_and_finish();
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check({31'h0, errv}, 32'h0, "bus error flag");
    check(rdv, e, "register read");
  endtask
  task automatic wait_lvl(ref logic s, input logic lvl, input int lim);
    int n;
    n = 0;
    while (s !== lvl && n < lim) begin
      n++;
      @(posedge clk);
    end
    if (n == lim) begin
      failures++;
      $display("CHECK FAILED %0t alarm level wait ran out", $time);
      tally_and_finish();
    end
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset_values();
    logic [7:0] ra[10] = '{ITS_A_CTRL, ITS_A_CT_UP, ITS_A_CT_LO,
      ITS_A_CT_DLY, ITS_A_U2_LIM, ITS_A_I2_LIM, ITS_A_VT_DLY,
      ITS_A_STATUS, ITS_A_UP_PRI, ITS_A_LO_PRI};
    logic [31:0] re[10] = '{32'hF, 32'h7D0, 32'hC8, 32'h64, 32'h15A,
      32'h3E8, 32'h64, 32'h0, 32'h30D40, 32'h4E20};
    for (int k = 0; k < 10; k++)
      rd_chk(ra[k], re[k]);
  endtask
  task automatic t_ranges();
    logic [7:0] wa[9] = '{ITS_A_CT_UP, ITS_A_CT_LO, ITS_A_VT_DLY,
      ITS_A_U2_LIM, ITS_A_I2_LIM, ITS_A_CT_UP, ITS_A_CT_LO,
      ITS_A_U2_LIM, ITS_A_I2_LIM};
    logic [31:0] wd[9] = '{32'hFFFF, 32'h3000, 32'h5, 32'h1000,
      32'h1000, 32'h7D0, 32'hC8, 32'h15A, 32'h3E8};
    logic [31:0] we[9] = '{32'h2710, 32'h2710, 32'h14, 32'h7D0,
      32'h7D0, 32'h7D0, 32'hC8, 32'h15A, 32'h3E8};
    for (int k = 0; k < 9; k++) begin
      apb(1'b1, wa[k], wd[k]);
      rd_chk(wa[k], we[k]);
    end
    apb(1'b1, ITS_A_CT_PRI, 32'hC8);
    rd_chk(ITS_A_UP_PRI, 32'h61A80);
    rd_chk(ITS_A_LO_PRI, 32'h9C40);
    apb(1'b1, ITS_A_LIVE_CT, 32'h12345678);
    rd_chk(ITS_A_LIVE_CT, 32'h0);
    apb(1'b0, 8'h50, 32'h0);
    check({31'h0, errv}, 32'h1, "unmapped error");
  endtask
  task automatic t_ct_alarm();
    mode <= 2'h1;
    repeat (3) @(posedge clk);
    rd_chk(ITS_A_LIVE_CT, 32'h0BB80064);
    repeat (940) @(posedge clk);
    check({31'h0, ct_alarm}, 32'h0, "alarm early");
    wait_lvl(ct_alarm, 1'b1, 100);
    check({31'h0, cur_xformer_alarm_start_event_en}, 32'h1, "CT start event");
    t_rise = ts_q;
    rd_chk(ITS_A_STATUS, 32'h101);
    check({31'h0, irq}, 32'h0, "masked irq");
    rd_chk(ITS_A_CT_RVAL, 32'h0BB80064);
    rd_chk(ITS_A_CT_RTLO, t_rise[31:0]);
    rd_chk(ITS_A_CT_RTHI, t_rise[63:32]);
    apb(1'b1, ITS_A_MASK, 32'h1);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h1, "irq raised");
    apb(1'b1, ITS_A_STATUS, 32'h1);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0, "irq cleared");
    mode <= 2'h0;
    wait_lvl(ct_alarm, 1'b0, 6);
    check({31'h0, cur_xformer_alarm_end_event_en}, 32'h1, "CT end event");
    rd_chk(ITS_A_STATUS, 32'h2);
    apb(1'b1, ITS_A_STATUS, 32'hF);
  endtask
  task automatic t_restart();
    mode <= 2'h1;
    repeat (600) @(posedge clk);
    mode <= 2'h0;
    repeat (3) @(posedge clk);
    mode <= 2'h1;
    slow <= 1'b1;
    repeat (600) @(posedge clk);
    check({31'h0, ct_alarm}, 32'h0, "delay not restarted");
    wait_lvl(ct_alarm, 1'b1, 500);
    mode <= 2'h0;
    wait_lvl(ct_alarm, 1'b0, 12);
    slow <= 1'b0;
    apb(1'b1, ITS_A_STATUS, 32'hF);
  endtask
  task automatic t_vt_alarm();
    apb(1'b1, ITS_A_CTRL, 32'hB);
    mode <= 2'h2;
    repeat (3) @(posedge clk);
    apb(1'b0, ITS_A_LIVE_VT, 32'h0);
    near(rdv[31:16], 16'd1000, 16'd150, "neg seq voltage");
    near(rdv[15:0], 16'd0, 16'd20, "neg seq current");
    repeat (150) @(posedge clk);
    check({31'h0, vt_alarm}, 32'h0, "alarm early");
    wait_lvl(vt_alarm, 1'b1, 100);
    check({31'h0, volt_xformer_alarm_start_event_en}, 32'h0, "VT start event disabled");
    t_rise = ts_q;
    rd_chk(ITS_A_STATUS, 32'h200);
    apb(1'b0, ITS_A_VT_RVAL, 32'h0);
    near(rdv[31:16], 16'd1000, 16'd150, "recorded voltage");
    near(rdv[15:0], 16'd0, 16'd20, "recorded current");
    rd_chk(ITS_A_VT_RTLO, t_rise[31:0]);
    apb(1'b1, ITS_A_CTRL, 32'hF);
    mode <= 2'h0;
    wait_lvl(vt_alarm, 1'b0, 6);
    check({31'h0, volt_xformer_alarm_end_event_en}, 32'h1, "VT end event");
    rd_chk(ITS_A_STATUS, 32'h8);
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {clk, nrst, psel, penable, pwrite, mode, slow} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    failures = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset_values();
    t_ranges();
    t_ct_alarm();
    t_restart();
    t_vt_alarm();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("CHECK FAILED %0t run limit reached", $time);
    tally_and_finish();
  end
endmodule
